// ===== vct_pkg.sv
// Package of constants and types for the voltage code tracking block
package vct_pkg;

    // ************************************************************
    // Clock and derived rates
    // ************************************************************
    localparam int CLK_HZ     = 100_000_000;
    localparam int SAMPLE_HZ  = 5_500_000;
    localparam int SLEW_HZ    = 345_000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int SLEW_DIV   = CLK_HZ / SLEW_HZ;

    // ************************************************************
    // Widths, counts and reset values
    // ************************************************************
    localparam int          CODE_W     = 8;
    localparam int          RUN_W      = 3;
    localparam int          MODE_W     = 2;
    localparam logic [2:0]  RUN_MAX    = 3'h7;
    localparam logic [2:0]  RUN_FIRST  = 3'h1;
    localparam logic [2:0]  ACCEPT_RUN = 3'h3;
    localparam logic [2:0]  OFF_RUN    = 3'h4;
    localparam logic [7:0]  CODE_RESET = 8'h00;
    localparam logic [7:0]  REF_RESET  = 8'h00;
    localparam logic [7:0]  REF_STEP   = 8'h01;

    // ************************************************************
    // Table modes, shut-off and no-load codes
    // ************************************************************
    localparam logic [1:0]  MODE_8BIT  = 2'h0;
    localparam logic [1:0]  MODE_5BIT  = 2'h1;
    localparam logic [1:0]  MODE_6BIT  = 2'h2;
    localparam logic [7:0]  OFF8_A     = 8'h00;
    localparam logic [7:0]  OFF8_B     = 8'h01;
    localparam logic [7:0]  OFF8_C     = 8'hfe;
    localparam logic [7:0]  OFF8_D     = 8'hff;
    localparam logic [4:0]  OFF5       = 5'h1f;
    localparam logic [4:0]  NOLOAD5    = 5'h1f;
    localparam logic [7:0]  MASK5      = 8'h1f;
    localparam logic [7:0]  MASK6      = 8'h3f;

    typedef enum logic [1:0] {
        VCT_ST_IDLE,
        VCT_ST_RUN,
        VCT_ST_OFF
    } vct_state_t;

endpackage : vct_pkg

// ===== vct_code_if.sv
// Interface between the sample qualifier and the tracking core
`timescale 1ns/1ps
interface vct_code_if;
    import vct_pkg::*;
    logic              tick;
    logic [CODE_W-1:0] code;
    logic [RUN_W-1:0]  run_len;
    logic [CODE_W-1:0] last_code;

    modport qual (input tick, input code, output run_len, output last_code);
    modport core (output tick, output code, input run_len, input last_code);
endinterface : vct_code_if

// ===== vct_div.sv
// Clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module vct_div
    import vct_pkg::*;
#(
    parameter int DIV = 2
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Enable pulse
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign tick = (cnt_q == LAST);
endmodule : vct_div

// ===== vct_qual.sv
// Counts uninterrupted runs of equal code samples
`timescale 1ns/1ps
module vct_qual
    import vct_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Code samples
    vct_code_if.qual  cif
);
    logic [RUN_W-1:0]  run_q;
    logic [CODE_W-1:0] last_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_q <= CODE_RESET;
        end else if (cif.tick) begin
            last_q <= cif.code;
        end
    end

    // Saturate so a long steady code never wraps back into a short run
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= '0;
        end else if (cif.tick) begin
            if (cif.code != last_q) begin
                run_q <= RUN_FIRST;
            end else if (run_q != RUN_MAX) begin
                run_q <= run_q + RUN_W'(1);
            end
        end
    end

    assign cif.run_len   = run_q;
    assign cif.last_code = last_q;

    property p_run_restart;
        @(posedge ref_clk) disable iff (!arst_n)
        (cif.tick && cif.code != last_q) |=> (run_q == RUN_FIRST);
    endproperty
    a_run_restart: assert property (p_run_restart)
        else $error("run length did not restart on a changed sample");
endmodule : vct_qual

// ===== vct_top.sv
// Voltage code sampling, qualification and reference tracking
`timescale 1ns/1ps
module vct_top
    import vct_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // Pins from the processor and board
    input  wire logic [CODE_W-1:0] voltage_code_inputs,
    input  wire logic [MODE_W-1:0] table_mode,
    input  wire logic              enable,
    // Reference and status
    output logic [CODE_W-1:0]      ref_units_q,
    output logic [CODE_W-1:0]      accepted_code_q,
    output logic                   code_accepted_q,
    output logic                   regulating_q,
    output logic                   shutoff_q,
    output logic                   slewing
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int SW = CODE_W + MODE_W + 1;

    logic [SW-1:0]     meta_q;
    logic [SW-1:0]     sync_q;
    logic [CODE_W-1:0] code_s;
    logic [MODE_W-1:0] mode_s;
    logic              en_s;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {enable, table_mode, voltage_code_inputs};
            sync_q <= meta_q;
        end
    end

    assign code_s = sync_q[CODE_W-1:0];
    assign mode_s = sync_q[CODE_W +: MODE_W];
    assign en_s   = sync_q[SW-1];

    // ************************************************************
    // Sampling and step clocks
    // ************************************************************
    logic sample_tick;
    logic slew_tick;

    vct_div #(.DIV(SAMPLE_DIV)) u_sample_div (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tick    (sample_tick)
    );

    vct_div #(.DIV(SLEW_DIV)) u_slew_div (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tick    (slew_tick)
    );

    // ************************************************************
    // Run qualification
    // ************************************************************
    vct_code_if cif ();

    assign cif.tick = sample_tick;
    assign cif.code = code_s;

    vct_qual u_qual (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .cif     (cif)
    );

    // Run length settles one cycle after the sampling pulse
    logic sampled_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sampled_q <= 1'b0;
        end else begin
            sampled_q <= sample_tick;
        end
    end

    logic accept_now;
    logic is_off;
    logic off_now;

    assign accept_now = sampled_q && (cif.run_len == ACCEPT_RUN)
                        && (cif.last_code != accepted_code_q);

    always_comb begin
        is_off = 1'b0;
        case (mode_s)
            MODE_8BIT: begin
                is_off = (cif.last_code == OFF8_A)
                      || (cif.last_code == OFF8_B)
                      || (cif.last_code == OFF8_C)
                      || (cif.last_code == OFF8_D);
            end
            MODE_5BIT: begin
                is_off = (cif.last_code[4:0] == OFF5);
            end
            default: begin
                is_off = 1'b0;
            end
        endcase
    end

    // Four samples, not three, so a code passing through an off value
    // during an ordinary transition cannot kill the output
    assign off_now = sampled_q && (cif.run_len == OFF_RUN) && is_off;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            accepted_code_q <= CODE_RESET;
        end else if (accept_now) begin
            accepted_code_q <= cif.last_code;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_accepted_q <= 1'b0;
        end else begin
            code_accepted_q <= accept_now;
        end
    end

    // ************************************************************
    // Enable, start-up and shut-off latch
    // ************************************************************
    vct_state_t state_q;
    logic       no_load;

    assign no_load = (mode_s == MODE_5BIT)
                     && (code_s[4:0] == NOLOAD5);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= VCT_ST_IDLE;
        end else begin
            case (state_q)
                VCT_ST_IDLE: begin
                    if (en_s && !no_load) begin
                        state_q <= VCT_ST_RUN;
                    end
                end
                VCT_ST_RUN: begin
                    if (!en_s) begin
                        state_q <= VCT_ST_IDLE;
                    end else if (off_now) begin
                        state_q <= VCT_ST_OFF;
                    end
                end
                VCT_ST_OFF: begin
                    if (!en_s) begin
                        state_q <= VCT_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= VCT_ST_IDLE;
                end
            endcase
        end
    end

    assign regulating_q = (state_q == VCT_ST_RUN);
    assign shutoff_q    = (state_q == VCT_ST_OFF);

    // ************************************************************
    // Reference tracking
    // ************************************************************
    logic [CODE_W-1:0] target;

    // Code value maps one to one onto 6.25 mV units; the table
    // voltage translation sits outside this block
    always_comb begin
        case (mode_s)
            MODE_5BIT: target = accepted_code_q & MASK5;
            MODE_6BIT: target = accepted_code_q & MASK6;
            default:   target = accepted_code_q;
        endcase
    end

    assign slewing = regulating_q && (mode_s != MODE_8BIT)
                     && (ref_units_q != target);

    // No step limit in 8-bit mode: a multi-step jump lands in one go
    // and can trip the power stage protection
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_units_q <= REF_RESET;
        end else if (!regulating_q) begin
            ref_units_q <= REF_RESET;
        end else if (mode_s == MODE_8BIT) begin
            if (accept_now) begin
                ref_units_q <= cif.last_code;
            end
        end else if (slew_tick && slewing) begin
            if (ref_units_q < target) begin
                ref_units_q <= ref_units_q + REF_STEP;
            end else begin
                ref_units_q <= ref_units_q - REF_STEP;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_sample_rate;
        @(posedge ref_clk) disable iff (!arst_n)
        sample_tick |-> ##18 sample_tick;
    endproperty
    a_sample_rate: assert property (p_sample_rate)
        else $error("sampling pulse spacing wrong");

    property p_accept_run;
        @(posedge ref_clk) disable iff (!arst_n)
        code_accepted_q |-> ($past(cif.run_len) == ACCEPT_RUN)
                            && $past(sampled_q);
    endproperty
    a_accept_run: assert property (p_accept_run)
        else $error("code accepted without three equal samples");

    property p_direct_load;
        @(posedge ref_clk) disable iff (!arst_n)
        (code_accepted_q && regulating_q && mode_s == MODE_8BIT
         && $past(regulating_q) && $stable(mode_s))
        |-> (ref_units_q == accepted_code_q);
    endproperty
    a_direct_load: assert property (p_direct_load)
        else $error("8-bit mode reference not loaded at once");

    property p_slew_step;
        @(posedge ref_clk) disable iff (!arst_n)
        (slewing && slew_tick && $stable(mode_s) && en_s
         && !off_now && ref_units_q < target)
        |=> (ref_units_q == $past(ref_units_q) + REF_STEP);
    endproperty
    a_slew_step: assert property (p_slew_step)
        else $error("slew did not step up by one unit");

    property p_slew_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        (regulating_q && mode_s != MODE_8BIT && !slew_tick && en_s
         && !off_now && $stable(mode_s))
        |=> $stable(ref_units_q);
    endproperty
    a_slew_hold: assert property (p_slew_hold)
        else $error("reference moved between step pulses");

    property p_off_run;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(shutoff_q) |-> ($past(cif.run_len) == OFF_RUN);
    endproperty
    a_off_run: assert property (p_off_run)
        else $error("shut-off taken without four equal samples");

    sequence s_latched_on;
        shutoff_q && en_s;
    endsequence
    sequence s_still_off;
        shutoff_q && !regulating_q;
    endsequence
    property p_off_latch;
        @(posedge ref_clk) disable iff (!arst_n)
        s_latched_on |=> s_still_off;
    endproperty
    a_off_latch: assert property (p_off_latch)
        else $error("shut-off latch released while enabled");

    property p_no_load;
        @(posedge ref_clk) disable iff (!arst_n)
        (!regulating_q && no_load) |=> !regulating_q;
    endproperty
    a_no_load: assert property (p_no_load)
        else $error("start-up began on no-load code");

endmodule : vct_top

// ===== vct_cpu_model.sv
// Processor model that drives the voltage code pins
`timescale 1ns/1ps
module vct_cpu_model
    import vct_pkg::*;
(
    // Clock
    input  wire logic         ref_clk,
    // Code pins
    output logic [CODE_W-1:0] voltage_code_inputs
);
    // ****************************************
    // Code driver
    // ****************************************
    initial voltage_code_inputs = 8'h40;

    // Pins only move off the sampling edge, so no sample sees a half change
    task automatic drive(input logic [CODE_W-1:0] code, input int hold);
        @(negedge ref_clk);
        voltage_code_inputs = code;
        repeat (hold) @(negedge ref_clk);
    endtask : drive
endmodule : vct_cpu_model

// ===== testbench.sv
// Self-checking testbench for the voltage code tracking block
`timescale 1ns/1ps
module testbench
    import vct_pkg::*;
;
    logic              ref_clk;
    logic              arst_n;
    logic [CODE_W-1:0] code;
    logic [MODE_W-1:0] table_mode;
    logic              enable;
    logic [CODE_W-1:0] ref_units_q;
    logic [CODE_W-1:0] accepted_code_q;
    logic              code_accepted_q;
    logic              regulating_q;
    logic              shutoff_q;
    logic              slewing;
    int                bad_count;
    int                n_checks;

    vct_cpu_model i_vct_cpu_model (
        .ref_clk             (ref_clk),
        .voltage_code_inputs (code)
    );

    vct_top i_vct_top (
        .ref_clk             (ref_clk),
        .arst_n              (arst_n),
        .voltage_code_inputs (code),
        .table_mode          (table_mode),
        .enable              (enable),
        .ref_units_q         (ref_units_q),
        .accepted_code_q     (accepted_code_q),
        .code_accepted_q     (code_accepted_q),
        .regulating_q        (regulating_q),
        .shutoff_q           (shutoff_q),
        .slewing             (slewing)
    );

    always #5 ref_clk = ~ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Kind 0 waits for an accept pulse, 1 for shut-off, 2 for slew end
    task automatic wait_for(input int kind, input int limit, output int n);
        logic hit;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            hit = (kind == 0) ? code_accepted_q === 1'b1 :
                  (kind == 1) ? shutoff_q === 1'b1 : slewing === 1'b0;
        end while (!hit && n < limit);
        if (!hit) begin
            check(kind, 16'hffff);
            complete_run();
        end
    endtask : wait_for

    // Restart regulation with a given mode and starting code
    task automatic restart(input logic [1:0] mode, input logic [7:0] c);
        enable = 1'b0;
        repeat (5) @(negedge ref_clk);
        table_mode = mode;
        i_vct_cpu_model.drive(c, 150);
        enable = 1'b1;
        repeat (150) @(negedge ref_clk);
    endtask : restart

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_track8;
        int n;
        enable = 1'b1;
        repeat (150) @(negedge ref_clk);
        check(regulating_q, 1'b1);
        i_vct_cpu_model.drive(8'h41, 0);
        wait_for(0, 150, n);
        check(n >= 38 && n <= 60, 1'b1);
        check(accepted_code_q, 8'h41);
        check(ref_units_q, 8'h41);
        check(slewing, 1'b0);
        @(negedge ref_clk);
        check(code_accepted_q, 1'b0);
        // Each too short to qualify: at most two samples see each code,
        // so only a counter that restarts on change keeps this quiet
        i_vct_cpu_model.drive(8'h42, 30);
        i_vct_cpu_model.drive(8'h43, 30);
        i_vct_cpu_model.drive(8'h41, 0);
        repeat (150) @(negedge ref_clk) check(code_accepted_q, 1'b0);
        check(ref_units_q, 8'h41);
        i_vct_cpu_model.drive(8'h50, 0);
        wait_for(0, 150, n);
        check(ref_units_q, 8'h50);
        $display("test track8 done");
    endtask : t_track8

    task automatic t_noload;
        restart(MODE_5BIT, 8'h1f);
        repeat (50) @(negedge ref_clk);
        check(regulating_q, 1'b0);
        check(ref_units_q, 8'h00);
        i_vct_cpu_model.drive(8'h02, 150);
        check(regulating_q, 1'b1);
        $display("test noload done");
    endtask : t_noload

    task automatic t_slew(input logic [1:0] mode, input logic [7:0] start,
                          input logic [7:0] target, input logic [7:0] msk);
        int         n;
        int         cnt;
        bit         first;
        logic [7:0] prev;
        logic [7:0] step;
        restart(mode, start);
        wait_for(2, 3000, n);
        check(ref_units_q, start & msk);
        i_vct_cpu_model.drive(target, 0);
        wait_for(0, 150, n);
        check(slewing, 1'b1);
        first = 1'b1;
        while (ref_units_q !== (target & msk)) begin
            prev = ref_units_q;
            cnt = 0;
            do begin
                @(negedge ref_clk);
                cnt++;
            end while (ref_units_q === prev && cnt < 400);
            step = ((target & msk) > prev) ? prev + 8'h01 : prev - 8'h01;
            check(ref_units_q, step);
            if (!first) check(cnt, SLEW_DIV);
            first = 1'b0;
            if (cnt >= 400) complete_run();
        end
        check(slewing, 1'b0);
        $display("test slew done");
    endtask : t_slew

    task automatic t_off;
        int         n;
        logic [1:0] modes [5] = '{MODE_8BIT, MODE_8BIT, MODE_8BIT,
                                  MODE_8BIT, MODE_5BIT};
        logic [7:0] codes [5] = '{OFF8_A, OFF8_B, OFF8_C, OFF8_D, MASK5};
        for (int i = 0; i < 5; i++) begin
            restart(modes[i], 8'h03);
            i_vct_cpu_model.drive(codes[i], 0);
            wait_for(0, 150, n);
            check(accepted_code_q, codes[i]);
            wait_for(1, 40, n);
            check(n, SAMPLE_DIV);
            check(regulating_q, 1'b0);
            // Reference clears on the edge after the latch sets
            @(negedge ref_clk);
            check(ref_units_q, 8'h00);
            i_vct_cpu_model.drive(8'h03, 150);
            check(shutoff_q, 1'b1);
            enable = 1'b0;
            repeat (5) @(negedge ref_clk);
            check(shutoff_q, 1'b0);
        end
        $display("test off done");
    endtask : t_off

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        enable = 1'b0;
        table_mode = MODE_8BIT;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(negedge ref_clk);
        check(ref_units_q, REF_RESET);
        check(regulating_q, 1'b0);
        check(shutoff_q, 1'b0);
        arst_n = 1'b1;
        t_track8();
        t_noload();
        t_slew(MODE_5BIT, 8'h03, 8'h06, MASK5);
        t_slew(MODE_6BIT, 8'h05, 8'hc1, MASK6);
        t_off();
        complete_run();
    end
endmodule : testbench
